// >>> verilog/e1pc_defines.svh
/*
  Constants for the E1 port violation counter and trail-trace control bank:
  register word indices, field positions, reset values and saturation limits.
  Assumes it is included by bare name from the design files.
*/
`ifndef E1PC_DEFINES_SVH
`define E1PC_DEFINES_SVH

// Register word indices (byte address is four times the index)
`define E1PC_P1_CV_LOW 8'h46
`define E1PC_P1_CV_HIGH 8'h47
`define E1PC_P1_OP_CTRL 8'h48
`define E1PC_P2_CV_LOW 8'h76
`define E1PC_P2_CV_HIGH 8'h77
`define E1PC_P2_OP_CTRL 8'h78
`define E1PC_P3_CV_LOW 8'ha6
`define E1PC_P3_CV_HIGH 8'ha7
`define E1PC_P3_OP_CTRL 8'ha8
`define E1PC_P4_CV_LOW 8'hd6
`define E1PC_P4_CV_HIGH 8'hd7
`define E1PC_P4_OP_CTRL 8'hd8
// Global control and per-port set control words
`define E1PC_GLOBAL_CTRL 8'hf0
`define E1PC_SET_CTRL 8'hf1

// Operation register fields
`define E1PC_OP_RDI_BIT 4
`define E1PC_OP_TEN_BIT 3
`define E1PC_OP_SIZE_BIT 2
`define E1PC_OP_COM_BIT 1
`define E1PC_OP_AISE_BIT 0
`define E1PC_OP_RESET 5'h00

// Control word fields
`define E1PC_GCTRL_RST_BIT 0
`define E1PC_SET_S_LSB 0
`define E1PC_SET_C_LSB 4

// Counter limits
`define E1PC_CNT_MAX 16'hffff
`define E1PC_CNT_RESET 16'h0000
`define E1PC_PEND_MAX 2'h3

`endif

// >>> verilog/e1pc_pkg.sv
/*
  Types shared by the E1 port violation counter bank.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package e1pc_pkg;
  // Bus handshake state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } e1pc_bus_state_e;
  // One register byte
  typedef logic [7:0] e1pc_byte_t;
  // Operation register image, bits 4..0
  typedef logic [4:0] e1pc_op_t;
endpackage
`default_nettype wire

// >>> verilog/e1pc_cnt_if.sv
/*
  Interface between the register bank and one port's violation counter.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface e1pc_cnt_if;
  logic cv_pulse; // One violation seen this cycle
  logic hold; // Host read in progress, park new events
  logic clear; // Zero the count this cycle
  logic [15:0] count; // Current count
  modport ctrl (output cv_pulse, output hold, output clear, input count);
  modport cnt (input cv_pulse, input hold, input clear, output count);
endinterface // e1pc_cnt_if
`default_nettype wire

// >>> verilog/e1pc_cv_counter.sv
/*
  One port's 16-bit saturating line-code violation counter with a small
  pending store for events that arrive during a host read.
  Assumes hold is asserted for at most a few cycles at a time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "e1pc_defines.svh"
module e1pc_cv_counter (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Control side
  e1pc_cnt_if.cnt bus
);

  logic [15:0] count_reg; // Running count
  logic [15:0] count_next; // Next count
  logic [1:0] pend_reg; // Events parked during a read
  logic [1:0] pend_next; // Next parked value
  logic [16:0] sum; // Wide sum before saturation

  ////////////////////////////////////////////////////////////////////////////
  // Next-state arithmetic
  always_comb begin
    sum = 17'h00000;
    pend_next = 2'h0;
    count_next = bus.clear ? `E1PC_CNT_RESET : count_reg;
    if (bus.hold) begin
      // Saturate parked events; a read lasts two cycles, so three is plenty
      if (pend_reg != `E1PC_PEND_MAX && bus.cv_pulse) begin
        pend_next = pend_reg + 2'h1;
      end else begin
        pend_next = pend_reg;
      end
    end else begin
      sum = {1'b0, count_next} + {15'h0000, pend_reg} + {16'h0000, bus.cv_pulse};
      count_next = sum[16] ? `E1PC_CNT_MAX : sum[15:0];
    end
  end

  // Count and pending store
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_reg <= `E1PC_CNT_RESET;
      pend_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
      pend_reg <= pend_next;
    end
  end

  assign bus.count = count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // stops at full
  AST_CNT_SATURATE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (count_reg == 16'hffff) && !bus.clear |=> count_reg == 16'hffff)
    else $error("violation counter wrapped past full scale");
  AST_CNT_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    bus.hold && !bus.clear |=> count_reg == $past(count_reg))
    else $error("violation counter moved during a host read");
  AST_CNT_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    bus.clear && bus.hold |=> count_reg == 16'h0000)
    else $error("violation counter not zeroed by clear");

endmodule // e1pc_cv_counter
`default_nettype wire

// >>> verilog/e1pc_port_bank.sv
/*
  Four-port violation counter and operation register bank for an E1
  tributary mapper, reached over an Avalon-MM slave with waitrequest.
  Assumes all inputs are synchronous to clk_sys_i and that violation
  inputs are one-cycle pulses from the line decoder.
*/
// Functional notes
// - Each port counts violations, saturating at 16 bits.
// - Violations during a host read are applied afterward.
// - Reset, control bits or low read zero counter.
// - Low read copies high byte to shared shadow.
// - High-byte read returns the shared shadow.
// - Bit 4 picks single-bit or 3-bit RDI.
// - Bit 3 sends stored trace, else zero.
// - Bit 2 sets trace segment size.
// - Size/compare pair: 16 off, 16 on, 64 off.
`timescale 1ns/1ps
`default_nettype none
`include "e1pc_defines.svh"
module e1pc_port_bank (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Line side
  input wire logic [3:0] cv_pulse_i,
  input wire logic line_reset_pulse_i,
  // Trail-trace message bytes from the message RAM, port n at [8n+7:8n]
  input wire logic [31:0] j2_ram_byte_i,
  // Per-port controls
  output logic [3:0] single_bit_defect_select_o,
  output logic [3:0] trace_message_send_enable_o,
  output logic [3:0] trace_segment_size_select_o,
  output logic [3:0] trace_compare_enable_o,
  output logic [3:0] trace_alarm_enable_o,
  output logic [3:0] trace_compare_active_o,
  output logic [3:0] trace_segment_64_o,
  output logic [31:0] j2_tx_byte_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address map as arrays so the decode is one loop
  localparam logic [7:0] LOW_IDX [4] = '{`E1PC_P1_CV_LOW, `E1PC_P2_CV_LOW,
    `E1PC_P3_CV_LOW, `E1PC_P4_CV_LOW};
  localparam logic [7:0] HIGH_IDX [4] = '{`E1PC_P1_CV_HIGH, `E1PC_P2_CV_HIGH,
    `E1PC_P3_CV_HIGH, `E1PC_P4_CV_HIGH};
  localparam logic [7:0] OP_IDX [4] = '{`E1PC_P1_OP_CTRL, `E1PC_P2_OP_CTRL,
    `E1PC_P3_OP_CTRL, `E1PC_P4_OP_CTRL};

  e1pc_pkg::e1pc_bus_state_e state_reg; // Handshake state
  logic [7:0] word_idx; // Register index from byte address
  logic acc; // Request taken this cycle
  logic rd_acc; // Read taken this cycle
  logic wr_acc; // Write taken with low lane enabled
  logic [3:0] lo_hit; // Low byte selected, per port
  logic [3:0] hi_hit; // High byte selected, per port
  logic [3:0] op_hit; // Operation register selected, per port
  logic gctrl_hit; // Global control word selected
  logic setc_hit; // Set control word selected
  logic [3:0] clr_vec; // Counter clear, per port
  logic [15:0] cnt_val [4]; // Counts from the counters
  e1pc_pkg::e1pc_op_t op_reg [4]; // Operation registers
  e1pc_pkg::e1pc_byte_t shadow_reg; // Shared high-byte holding location
  e1pc_pkg::e1pc_byte_t shadow_next; // Next shadow
  logic [31:0] rd_next; // Read data for the taken read
  logic [31:0] readdata_reg; // Registered read data
  logic waitrequest_reg; // Registered waitrequest
  logic [3:0] cmp_active_reg; // Comparison really running
  logic [3:0] seg64_reg; // 64-byte segments in force
  logic [31:0] j2_reg; // Outgoing trace bytes

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign word_idx = avs_address_i[9:2];
  assign acc = (state_reg == e1pc_pkg::BUS_IDLE) && (avs_read_i || avs_write_i);
  assign rd_acc = acc && avs_read_i;
  assign wr_acc = acc && avs_write_i && avs_byteenable_i[0];
  assign gctrl_hit = (word_idx == `E1PC_GLOBAL_CTRL);
  assign setc_hit = (word_idx == `E1PC_SET_CTRL);

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      lo_hit[p] = (word_idx == LOW_IDX[p]);
      hi_hit[p] = (word_idx == HIGH_IDX[p]);
      op_hit[p] = (word_idx == OP_IDX[p]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port counters and clear sources
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      e1pc_cnt_if cif();
      assign clr_vec[g] = line_reset_pulse_i
        || (wr_acc && gctrl_hit && avs_writedata_i[`E1PC_GCTRL_RST_BIT])
        || (wr_acc && setc_hit && avs_writedata_i[`E1PC_SET_S_LSB + g])
        || (wr_acc && setc_hit && avs_writedata_i[`E1PC_SET_C_LSB + g])
        || (rd_acc && lo_hit[g]);
      assign cif.cv_pulse = cv_pulse_i[g];
      assign cif.hold = avs_read_i;
      assign cif.clear = clr_vec[g];
      assign cnt_val[g] = cif.count;
      e1pc_cv_counter u_cnt (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .bus(cif.cnt)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data and shadow selection
  always_comb begin
    rd_next = 32'h00000000;
    shadow_next = shadow_reg;
    for (int p = 0; p < 4; p++) begin
      if (lo_hit[p]) begin
        rd_next = {24'h000000, cnt_val[p][7:0]};
        shadow_next = cnt_val[p][15:8];
      end
      if (hi_hit[p]) begin
        rd_next = {24'h000000, shadow_reg};
      end
      // Unused bits 7..5 read as zero
      if (op_hit[p]) begin
        rd_next = {27'h0000000, op_reg[p]};
      end
    end
  end

  // Shared shadow, loaded only on a taken low-byte read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shadow_reg <= 8'h00;
    end else if (rd_acc) begin
      shadow_reg <= shadow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer for one cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= e1pc_pkg::BUS_IDLE;
      waitrequest_reg <= 1'b1;
    end else begin
      case (state_reg)
        e1pc_pkg::BUS_IDLE: begin
          // Idle answers nothing until a request arrives
          if (acc) begin
            state_reg <= e1pc_pkg::BUS_ACK;
            waitrequest_reg <= 1'b0;
          end
        end
        e1pc_pkg::BUS_ACK: begin
          // Master samples the answer here and releases the request
          state_reg <= e1pc_pkg::BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
        default: begin
          state_reg <= e1pc_pkg::BUS_IDLE;
          waitrequest_reg <= 1'b1;
        end
      endcase
    end
  end

  // Read data captured when the read is taken, unmapped reads give zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      readdata_reg <= 32'h00000000;
    end else if (rd_acc) begin
      readdata_reg <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation registers; bits 7..5 are dropped since software keeps them 0
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < 4; p++) begin
        op_reg[p] <= `E1PC_OP_RESET;
      end
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (wr_acc && op_hit[p]) begin
          op_reg[p] <= avs_writedata_i[4:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trace size/compare decode and outgoing trace byte
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmp_active_reg <= 4'h0;
      seg64_reg <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        seg64_reg[p] <= op_reg[p][`E1PC_OP_SIZE_BIT];
        cmp_active_reg[p] <= !op_reg[p][`E1PC_OP_SIZE_BIT]
          && op_reg[p][`E1PC_OP_COM_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      j2_reg <= 32'h00000000;
    end else begin
      for (int p = 0; p < 4; p++) begin
        j2_reg[8*p +: 8] <= op_reg[p][`E1PC_OP_TEN_BIT]
          ? j2_ram_byte_i[8*p +: 8] : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign avs_readdata_o = readdata_reg;
  assign avs_waitrequest_o = waitrequest_reg;
  assign trace_compare_active_o = cmp_active_reg;
  assign trace_segment_64_o = seg64_reg;
  assign j2_tx_byte_o = j2_reg;

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      single_bit_defect_select_o[p] = op_reg[p][`E1PC_OP_RDI_BIT];
      trace_message_send_enable_o[p] = op_reg[p][`E1PC_OP_TEN_BIT];
      trace_segment_size_select_o[p] = op_reg[p][`E1PC_OP_SIZE_BIT];
      trace_compare_enable_o[p] = op_reg[p][`E1PC_OP_COM_BIT];
      trace_alarm_enable_o[p] = op_reg[p][`E1PC_OP_AISE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks, sampled one edge after the access that they follow
  // shadow load
  AST_SHADOW_COPY: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_acc && lo_hit[2] |=> shadow_reg == $past(cnt_val[2][15:8]))
    else $error("shadow not loaded from the port high byte");
  AST_SHADOW_KEEP: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !(rd_acc && (lo_hit != 4'h0)) |=> shadow_reg == $past(shadow_reg))
    else $error("shadow changed without a low-byte read");
  AST_HIGH_FROM_SHADOW: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_acc && (hi_hit != 4'h0) |=> avs_readdata_o == {24'h000000, shadow_reg}
      && !avs_waitrequest_o)
    else $error("high-byte read did not return the shadow");
  AST_LOW_DATA: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_acc && lo_hit[1] |=> avs_readdata_o
      == {24'h000000, $past(cnt_val[1][7:0])})
    else $error("low-byte read did not return the count");
  AST_LOW_CLEARS: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_acc && lo_hit[0] |=> cnt_val[0] == 16'h0000)
    else $error("low-byte read did not zero the count");
  AST_GLOBAL_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_acc && gctrl_hit && avs_writedata_i[`E1PC_GCTRL_RST_BIT]
      && !cv_pulse_i[2] && !$past(avs_read_i) |=> cnt_val[2] == 16'h0000)
    else $error("global clear did not zero the count");
  AST_SET_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_acc && setc_hit && avs_writedata_i[`E1PC_SET_C_LSB + 1]
      && !cv_pulse_i[1] && !$past(avs_read_i) |=> cnt_val[1] == 16'h0000)
    else $error("set control did not zero the count");
  AST_LINE_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    line_reset_pulse_i && !cv_pulse_i[3] && !$past(avs_read_i)
      |=> cnt_val[3] == 16'h0000)
    else $error("line reset pulse did not zero the count");
  AST_RDI_SELECT: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_acc && op_hit[1] |=> single_bit_defect_select_o[1]
      == $past(avs_writedata_i[`E1PC_OP_RDI_BIT]))
    else $error("RDI select did not follow the write");
  // Low lane off, nothing stored
  AST_LANE_OFF: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    acc && avs_write_i && !avs_byteenable_i[0]
      |=> single_bit_defect_select_o == $past(single_bit_defect_select_o))
    else $error("write with the low lane off changed a register");
  AST_SEND_WRITE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_acc && op_hit[2] |=> trace_message_send_enable_o[2]
      == $past(avs_writedata_i[`E1PC_OP_TEN_BIT]))
    else $error("send enable did not follow the write");
  AST_J2_ZERO: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !trace_message_send_enable_o[0] |=> j2_tx_byte_o[7:0] == 8'h00)
    else $error("trace byte not zero while sending is off");
  AST_J2_SEND: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    trace_message_send_enable_o[1]
      |=> j2_tx_byte_o[15:8] == $past(j2_ram_byte_i[15:8]))
    else $error("trace byte not taken from the message store");
  AST_SEG64: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    trace_segment_size_select_o[3]
      |=> trace_segment_64_o[3] && !trace_compare_active_o[3])
    else $error("64-byte size did not take effect");
  AST_CMP_ON: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !trace_segment_size_select_o[0] && trace_compare_enable_o[0]
      |=> trace_compare_active_o[0] && !trace_segment_64_o[0])
    else $error("16-byte compare mode not active");
  AST_CMP_OFF: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !trace_compare_enable_o[2] |=> !trace_compare_active_o[2])
    else $error("comparison running while disabled");
  // One wait cycle per access
  AST_ONE_WAIT: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    acc |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after the request");

endmodule // e1pc_port_bank
`default_nettype wire

// >>> dv/e1pc_host_model.sv
/*
  Host processor model: an Avalon-MM master that issues single transfers.
  Assumes a slave on the same clock that answers with waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none
module e1pc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Avalon-MM master side
  output logic [9:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus from time zero
  initial begin
    avs_address_o = 10'h000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h00000000;
    avs_byteenable_o = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One transfer held until waitrequest is seen low; ok low on a hang
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_o <= {idx, 2'b00};
    avs_read_o <= !wr;
    avs_write_o <= wr;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    // Bounded wait so a dead slave cannot stall the run
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_i !== 1'b0 && n < 64);
    ok = (avs_waitrequest_i === 1'b0);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask
endmodule // e1pc_host_model
`default_nettype wire

// >>> dv/e1pc_port_bank_tb.sv
/*
  Self-checking bench for the port bank: a queue-free integer model of
  counters, shadow and operation registers checked at every result.
  Assumes the host model sits on the register bus.
*/
`timescale 1ns/1ps
`default_nettype none
`include "e1pc_defines.svh"
module e1pc_port_bank_tb;
  // Clock, reset and line side stimulus
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] cv = 4'h0;
  logic lrst = 1'b0;
  logic [31:0] ram = 32'h00000000;
  // Bus wires
  logic [9:0] adr;
  logic rd_s, wr_s, wait_s;
  logic [31:0] wdat, rdat, j2;
  logic [3:0] be, sbd, tse, tss, tce, tae, tca, ts64;
  // Scoreboard state
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 35022;
  int cnt [4];
  int shadow;
  logic [7:0] op [4];
  logic [7:0] base [4] = '{`E1PC_P1_CV_LOW, `E1PC_P2_CV_LOW,
                           `E1PC_P3_CV_LOW, `E1PC_P4_CV_LOW};

  always #12.5 clk_sys_i = ~clk_sys_i;

  e1pc_host_model i_host (.clk_sys_i(clk_sys_i), .avs_address_o(adr),
    .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdat),
    .avs_byteenable_o(be), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wait_s));

  e1pc_port_bank i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_s), .cv_pulse_i(cv), .line_reset_pulse_i(lrst),
    .j2_ram_byte_i(ram), .single_bit_defect_select_o(sbd),
    .trace_message_send_enable_o(tse), .trace_segment_size_select_o(tss),
    .trace_compare_enable_o(tce), .trace_alarm_enable_o(tae),
    .trace_compare_active_o(tca), .trace_segment_64_o(ts64),
    .j2_tx_byte_o(j2));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value with the model
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus access; upper write bits are random since the slave ignores them
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    logic ok;
    logic [31:0] r;
    r = $random(seed);
    i_host.xfer(w, idx, {r[31:8], d}, b, q, ok);
    if (!ok) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] idx, input int e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, 4'h1, q);
    cmp("readdata", e, q);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, idx, d, b, q);
  endtask

  // Low read returns low byte, loads the shadow and clears the count
  task automatic rd_lo(input int p);
    int e;
    e = cnt[p] & 8'hff;
    shadow = cnt[p] >> 8;
    cnt[p] = 0;
    rd(base[p], e);
  endtask

  task automatic rd_hi(input int p);
    rd(base[p] + 8'h01, shadow);
  endtask

  // Operation register reads back bits 4..0 only
  task automatic rd_op(input int p);
    rd(base[p] + 8'h02, op[p] & 8'h1f);
  endtask

  // Every port read low then high, the order the host must keep
  task automatic chk_all();
    for (int p = 0; p < 4; p++) begin
      rd_lo(p);
      rd_hi(p);
    end
  endtask

  // Control outputs against the operation register images
  task automatic chk_out();
    @(posedge clk_sys_i);
    ram <= $random(seed);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    for (int p = 0; p < 4; p++) begin
      cmp("rdi_select", op[p][4], sbd[p]);
      cmp("send_enable", op[p][3], tse[p]);
      cmp("size_select", op[p][2], tss[p]);
      cmp("compare_enable", op[p][1], tce[p]);
      cmp("alarm_enable", op[p][0], tae[p]);
      cmp("compare_active", !op[p][2] && op[p][1], tca[p]);
      cmp("segment_64", op[p][2], ts64[p]);
      cmp("j2_byte", op[p][3] ? ram[8*p+:8] : 8'h00, j2[8*p+:8]);
    end
  endtask

  // Violation pulses, random masks or a fixed one, with saturation
  task automatic pulse(input logic [3:0] m, input int n, input bit rnd);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      if (rnd) begin
        r[3:0] = m | r[3:0];
      end else begin
        r[3:0] = m;
      end
      @(posedge clk_sys_i);
      cv <= r[3:0];
      for (int p = 0; p < 4; p++) begin
        if (r[p] && cnt[p] < 65535) begin
          cnt[p]++;
        end
      end
    end
    @(posedge clk_sys_i);
    cv <= 4'h0;
  endtask

  task automatic model_reset();
    for (int p = 0; p < 4; p++) begin
      cnt[p] = 0;
      op[p] = 8'h00;
    end
    shadow = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] d;
    model_reset();
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    // Reset values and an unmapped word
    chk_all();
    for (int p = 0; p < 4; p++) rd_op(p);
    rd(8'h10, 0);
    // Every size and compare pairing on every port, bits 7..5 zero
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 4; p++) begin
        d = ($random(seed) & 8'h19) | (r << 1);
        wr(base[p] + 8'h02, d, 4'h1);
        op[p] = d;
        rd_op(p);
      end
      chk_out();
    end
    // Low byte lane off: write ignored
    wr(base[0] + 8'h02, 8'h1f, 4'he);
    rd_op(0);
    // Random counting, then paired reads
    pulse(4'h0, 300, 1'b1);
    chk_all();
    // Two low reads before a high read: shadow follows the later port
    pulse(4'h0, 600, 1'b1);
    rd_lo(0);
    rd_lo(1);
    rd_hi(3);
    // Violations during a low read survive its clear
    fork
      rd_lo(0);
      begin
        @(posedge clk_sys_i);
        cv <= 4'h1;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        cv <= 4'h0;
      end
    join
    cnt[0] = 2;
    rd_lo(0);
    // Global clear, both set controls, line reset pulse
    pulse(4'h0, 50, 1'b1);
    wr(`E1PC_GLOBAL_CTRL, 8'h01, 4'h1);
    for (int p = 0; p < 4; p++) cnt[p] = 0;
    chk_all();
    pulse(4'h0, 50, 1'b1);
    wr(`E1PC_SET_CTRL, 8'h01, 4'h1);
    cnt[0] = 0;
    chk_all();
    pulse(4'h0, 50, 1'b1);
    wr(`E1PC_SET_CTRL, 8'h20, 4'h1);
    cnt[1] = 0;
    chk_all();
    pulse(4'h0, 50, 1'b1);
    @(posedge clk_sys_i);
    lrst <= 1'b1;
    @(posedge clk_sys_i);
    lrst <= 1'b0;
    for (int p = 0; p < 4; p++) cnt[p] = 0;
    chk_all();
    // Full scale holds instead of wrapping
    pulse(4'hf, 65540, 1'b0);
    chk_all();
    // Second reset in mid run
    pulse(4'h0, 20, 1'b1);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    model_reset();
    chk_out();
    chk_all();
    end_sim();
  end
endmodule // e1pc_port_bank_tb
`default_nettype wire
